//--- twi_pkg.sv
// Shared constants and types for the two-wire slave framing block and its bus master
// Notes on behaviour
// - Bus idle when both lines high
// - Data falling with clock high is start
// - Data rising with clock high is stop
// - Start opens; stop or repeated start closes
// - Byte count per transfer is unlimited
// - Early end after first byte keeps only MSB
// - Receiver pulls data low in ninth pulse
// - Master ends read with not-acknowledge
// - First written byte loads the register pointer
// - Address: five fixed bits plus two select pins
// - Register words go out MSB first
// - Long clock low resets and releases bus
package twi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 20000000;
  localparam int TIMEOUT_MS     = 30;
  // Longest time, so integer division rounds down
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int TIMEOUT_W      = 20;
  localparam int SCL_HZ         = 100000;
  localparam int QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);
  localparam int QUARTER_W      = 6;

  // ----------------------------------------------------------------
  // Addressing and byte kinds
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_FIXED   = 5'h12;
  localparam logic [1:0] KIND_POINTER = 2'h0;
  localparam logic [1:0] KIND_MSB     = 2'h1;
  localparam logic [1:0] KIND_LSB     = 2'h2;
  localparam int         FIFO_WIDTH   = 10;

  typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} cmd_t;

endpackage

//--- twi_if.sv
// Open-drain two-wire bus joining the slave and the master
`timescale 1ns/10ps
interface twi_if;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic scl_dev_o;
  logic scl_dev_oe_n;
  logic sda_mst_o;
  logic sda_mst_oe_n;
  logic scl_mst_o;
  logic scl_mst_oe_n;
  logic sda;
  logic scl;

  // Pull-ups win unless a party enables a low
  assign sda = (sda_dev_oe_n | sda_dev_o) & (sda_mst_oe_n | sda_mst_o);
  assign scl = (scl_dev_oe_n | scl_dev_o) & (scl_mst_oe_n | scl_mst_o);

  modport device (input sda, scl, output sda_dev_o, sda_dev_oe_n, scl_dev_o, scl_dev_oe_n);
  modport master (input sda, scl, output sda_mst_o, sda_mst_oe_n, scl_mst_o, scl_mst_oe_n);
endinterface

//--- twi_fifo2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module twi_fifo2 #(
  parameter int WIDTH = twi_pkg::FIFO_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic             tail_valid;
  logic [WIDTH-1:0] tail;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             next_tail_valid;
  logic [WIDTH-1:0] next_tail;
  logic             pop;
  logic             push;

  assign in_ready = ~tail_valid;

  always_comb
  begin
    pop             = out_valid & out_ready;
    push            = in_valid & ~tail_valid;
    next_out_valid  = out_valid;
    next_out_data   = out_data;
    next_tail_valid = tail_valid;
    next_tail       = tail;
    if (pop)
    begin
      next_out_valid  = tail_valid | push;
      next_out_data   = tail_valid ? tail : in_data;
      next_tail_valid = 1'b0;
    end
    else if (push)
    begin
      if (!out_valid)
      begin
        next_out_valid = 1'b1;
        next_out_data  = in_data;
      end
      else
      begin
        next_tail_valid = 1'b1;
        next_tail       = in_data;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid  <= 1'b0;
      out_data   <= '0;
      tail_valid <= 1'b0;
      tail       <= '0;
    end
    else
    begin
      out_valid  <= next_out_valid;
      out_data   <= next_out_data;
      tail_valid <= next_tail_valid;
      tail       <= next_tail;
    end
  end
endmodule

//--- twi_slave.sv
// Two-wire slave: condition detection, byte framing and acknowledge
`timescale 1ns/10ps
module twi_slave #(
  parameter int TIMEOUT_CYCLES = twi_pkg::TIMEOUT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  address_select_pin,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        rx_ready,
  output logic             rx_valid,
  output logic      [7:0]  rx_data,
  output logic      [1:0]  rx_kind,
  output logic      [7:0]  pointer,
  twi_if.device            bus
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT
  } state_t;

  // ----------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       sda_q;
  logic       scl_q;
  logic       sda_s;
  logic       scl_s;
  logic [1:0] asel;
  logic       start_cond;
  logic       stop_cond;
  logic       scl_rise;
  logic       scl_fall;

  // Reset high so a released bus gives no false edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
      sda_q <= 1'b1;
      scl_q <= 1'b1;
    end
    else
    begin
      sync1 <= {address_select_pin, bus.sda, bus.scl};
      sync2 <= sync1;
      sda_q <= sync2[1];
      scl_q <= sync2[0];
    end
  end

  assign sda_s      = sync2[1];
  assign scl_s      = sync2[0];
  assign asel       = sync2[3:2];
  assign start_cond = scl_q & scl_s & sda_q & ~sda_s;
  assign stop_cond  = scl_q & scl_s & ~sda_q & sda_s;
  assign scl_rise   = scl_s & ~scl_q;
  assign scl_fall   = ~scl_s & scl_q;

  // ----------------------------------------------------------------
  // Framing state
  // ----------------------------------------------------------------
  state_t                       state;
  state_t                       next_state;
  logic   [2:0]                 bit_cnt;
  logic   [2:0]                 next_bit_cnt;
  logic   [7:0]                 shreg;
  logic   [7:0]                 next_shreg;
  logic                         byte_done;
  logic                         next_byte_done;
  logic                         rw;
  logic                         next_rw;
  logic   [1:0]                 wbyte;
  logic   [1:0]                 next_wbyte;
  logic                         tx_lsb;
  logic                         next_tx_lsb;
  logic                         sda_oe_n;
  logic                         next_sda_oe_n;
  logic   [7:0]                 next_pointer;
  logic   [twi_pkg::TIMEOUT_W-1:0] tmo_cnt;
  logic   [twi_pkg::TIMEOUT_W-1:0] next_tmo_cnt;
  logic                         push;
  logic                         next_push;
  logic   [9:0]                 push_data;
  logic   [9:0]                 next_push_data;
  logic                         fifo_in_ready;
  logic   [7:0]                 tx_byte;

  function automatic logic [7:0] word_byte(input logic [15:0] word, input logic lsb);
    word_byte = lsb ? word[7:0] : word[15:8];
  endfunction

  always_comb
  begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_byte_done = byte_done;
    next_rw        = rw;
    next_wbyte     = wbyte;
    next_tx_lsb    = tx_lsb;
    next_sda_oe_n  = sda_oe_n;
    next_pointer   = pointer;
    next_push      = 1'b0;
    next_push_data = push_data;
    tx_byte        = word_byte(reg_rdata, ~tx_lsb);
    // Counts only while a transfer is open and the clock is low
    if (scl_s || state == ST_IDLE)
      next_tmo_cnt = '0;
    else
      next_tmo_cnt = tmo_cnt + 1'b1;

    if (tmo_cnt == twi_pkg::TIMEOUT_W'(TIMEOUT_CYCLES - 1))
    begin
      next_state    = ST_IDLE;
      next_sda_oe_n = 1'b1;
    end
    else if (start_cond)
    begin
      next_state     = ST_ADDR;
      next_bit_cnt   = 3'h0;
      next_byte_done = 1'b0;
      next_sda_oe_n  = 1'b1;
    end
    else if (stop_cond)
    begin
      next_state    = ST_IDLE;
      next_sda_oe_n = 1'b1;
    end
    else
    begin
      case (state)
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            next_shreg   = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
              next_byte_done = 1'b1;
          end
          else if (scl_fall && byte_done)
          begin
            next_byte_done = 1'b0;
            if (state == ST_ADDR)
            begin
              if (shreg[7:1] == {twi_pkg::ADDR_FIXED, asel})
              begin
                next_state    = ST_ADDR_ACK;
                next_sda_oe_n = 1'b0;
                next_rw       = shreg[0];
                next_wbyte    = 2'h0;
                next_tx_lsb   = 1'b1;
              end
              else
                next_state = ST_WAIT;
            end
            else if (fifo_in_ready)
            begin
              // A full buffer answers with not-acknowledge instead of losing the byte
              next_state    = ST_RX_ACK;
              next_sda_oe_n = 1'b0;
              next_push     = 1'b1;
              if (wbyte == 2'h0)
              begin
                next_pointer   = shreg;
                next_push_data = {twi_pkg::KIND_POINTER, shreg};
              end
              else if (wbyte == 2'h1)
                next_push_data = {twi_pkg::KIND_MSB, shreg};
              else
                next_push_data = {twi_pkg::KIND_LSB, shreg};
              next_wbyte = (wbyte == 2'h2) ? 2'h1 : wbyte + 2'h1;
            end
            else
              next_state = ST_WAIT;
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            next_bit_cnt = 3'h0;
            if (rw)
            begin
              next_state    = ST_TX;
              next_tx_lsb   = 1'b0;
              next_shreg    = tx_byte;
              next_sda_oe_n = tx_byte[7];
            end
            else
            begin
              next_state    = ST_RX;
              next_sda_oe_n = 1'b1;
            end
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            next_state    = ST_RX;
            next_sda_oe_n = 1'b1;
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
              next_byte_done = 1'b1;
          end
          else if (scl_fall)
          begin
            if (byte_done)
            begin
              next_state     = ST_TX_ACK;
              next_byte_done = 1'b0;
              next_sda_oe_n  = 1'b1;
            end
            else
            begin
              next_shreg    = {shreg[6:0], 1'b0};
              next_sda_oe_n = shreg[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
              next_state = ST_WAIT;
            else
              next_byte_done = 1'b1;
          end
          else if (scl_fall && byte_done)
          begin
            next_state     = ST_TX;
            next_byte_done = 1'b0;
            next_bit_cnt   = 3'h0;
            next_tx_lsb    = ~tx_lsb;
            next_shreg     = tx_byte;
            next_sda_oe_n  = tx_byte[7];
          end
        end
        default:
          next_sda_oe_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      bit_cnt   <= 3'h0;
      shreg     <= 8'h00;
      byte_done <= 1'b0;
      rw        <= 1'b0;
      wbyte     <= 2'h0;
      tx_lsb    <= 1'b0;
      sda_oe_n  <= 1'b1;
      pointer   <= 8'h00;
      tmo_cnt   <= '0;
      push      <= 1'b0;
      push_data <= 10'h000;
    end
    else
    begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      byte_done <= next_byte_done;
      rw        <= next_rw;
      wbyte     <= next_wbyte;
      tx_lsb    <= next_tx_lsb;
      sda_oe_n  <= next_sda_oe_n;
      pointer   <= next_pointer;
      tmo_cnt   <= next_tmo_cnt;
      push      <= next_push;
      push_data <= next_push_data;
    end
  end

  // ----------------------------------------------------------------
  // Received bytes to the register side
  // ----------------------------------------------------------------
  twi_fifo2 #(.WIDTH(twi_pkg::FIFO_WIDTH)) rx_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  ({rx_kind, rx_data})
  );

  assign bus.sda_dev_o    = 1'b0;
  assign bus.sda_dev_oe_n = sda_oe_n;
  assign bus.scl_dev_o    = 1'b0;
  assign bus.scl_dev_oe_n = 1'b1;
endmodule

//--- twi_master.sv
// Two-wire bus master driven by a simple command port
`timescale 1ns/10ps
module twi_master (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          cmd_valid,
  input  twi_pkg::cmd_t      cmd_kind,
  input  wire logic [7:0]    cmd_data,
  input  wire logic          cmd_last,
  output logic               cmd_ready,
  output logic               rsp_valid,
  output logic      [7:0]    rsp_data,
  output logic               rsp_nack,
  twi_if.master              bus
);
  typedef enum logic [2:0] {M_IDLE, M_HELD, M_START, M_BYTE, M_STOP} mstate_t;

  logic [1:0] sync1;
  logic [1:0] sync2;
  logic       bus_idle;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
    end
    else
    begin
      sync1 <= {bus.sda, bus.scl};
      sync2 <= sync1;
    end
  end

  assign bus_idle = sync2[1] & sync2[0];

  mstate_t                       state;
  mstate_t                       next_state;
  logic [twi_pkg::QUARTER_W-1:0] qcnt;
  logic [twi_pkg::QUARTER_W-1:0] next_qcnt;
  logic [1:0]                    phase;
  logic [1:0]                    next_phase;
  logic [3:0]                    bit_idx;
  logic [3:0]                    next_bit_idx;
  logic [7:0]                    shreg;
  logic [7:0]                    next_shreg;
  logic                          rd;
  logic                          next_rd;
  logic                          last;
  logic                          next_last;
  logic                          scl_oe_n;
  logic                          next_scl_oe_n;
  logic                          sda_oe_n;
  logic                          next_sda_oe_n;
  logic                          next_cmd_ready;
  logic                          next_rsp_valid;
  logic [7:0]                    next_rsp_data;
  logic                          next_rsp_nack;
  logic                          tick;

  always_comb
  begin
    next_state     = state;
    next_phase     = phase;
    next_bit_idx   = bit_idx;
    next_shreg     = shreg;
    next_rd        = rd;
    next_last      = last;
    next_scl_oe_n  = scl_oe_n;
    next_sda_oe_n  = sda_oe_n;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data;
    next_rsp_nack  = rsp_nack;
    tick = (qcnt == twi_pkg::QUARTER_W'(twi_pkg::QUARTER_CYCLES - 1));
    if (state == M_IDLE || state == M_HELD || tick)
      next_qcnt = '0;
    else
      next_qcnt = qcnt + 1'b1;

    case (state)
      M_IDLE, M_HELD:
      begin
        if (cmd_valid && cmd_ready)
        begin
          next_phase = 2'h0;
          if (cmd_kind == twi_pkg::CMD_START)
          begin
            next_state    = M_START;
            next_sda_oe_n = 1'b1;
            if (state == M_IDLE)
              next_phase = 2'h1;
          end
          else if (state == M_HELD && cmd_kind == twi_pkg::CMD_STOP)
          begin
            next_state    = M_STOP;
            next_sda_oe_n = 1'b0;
          end
          else if (state == M_HELD)
          begin
            next_state    = M_BYTE;
            next_bit_idx  = 4'h0;
            next_shreg    = cmd_data;
            next_rd       = (cmd_kind == twi_pkg::CMD_READ);
            next_last     = cmd_last;
            next_sda_oe_n = (cmd_kind == twi_pkg::CMD_READ) | cmd_data[7];
          end
        end
      end
      M_START:
      begin
        if (tick)
        begin
          next_phase = phase + 2'h1;
          if (phase == 2'h0)
            next_scl_oe_n = 1'b1;
          else if (phase == 2'h1)
            next_sda_oe_n = 1'b0;
          else if (phase == 2'h2)
            next_scl_oe_n = 1'b0;
          else
          begin
            next_state     = M_HELD;
            next_rsp_valid = 1'b1;
          end
        end
      end
      M_STOP:
      begin
        if (tick)
        begin
          next_phase = phase + 2'h1;
          if (phase == 2'h0)
            next_scl_oe_n = 1'b1;
          else if (phase == 2'h1)
            next_sda_oe_n = 1'b1;
          else
          begin
            next_state     = M_IDLE;
            next_rsp_valid = 1'b1;
          end
        end
      end
      M_BYTE:
      begin
        if (tick)
        begin
          next_phase = phase + 2'h1;
          if (phase == 2'h0)
            next_scl_oe_n = 1'b1;
          else if (phase == 2'h1)
          begin
            if (bit_idx == 4'h8)
              next_rsp_nack = sync2[1];
            else
              next_shreg = {shreg[6:0], sync2[1]};
          end
          else if (phase == 2'h2)
            next_scl_oe_n = 1'b0;
          else if (bit_idx == 4'h8)
          begin
            next_state     = M_HELD;
            next_rsp_valid = 1'b1;
            next_rsp_data  = shreg;
            next_sda_oe_n  = 1'b1;
          end
          else
          begin
            next_bit_idx = bit_idx + 4'h1;
            if (bit_idx == 4'h7)
              next_sda_oe_n = rd ? last : 1'b1;
            else
              next_sda_oe_n = rd | shreg[7];
          end
        end
      end
      default:
        next_state = M_IDLE;
    endcase
    next_cmd_ready = (next_state == M_HELD) || (next_state == M_IDLE && bus_idle);
    if (cmd_valid && cmd_ready && next_state != state)
      next_cmd_ready = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state     <= M_IDLE;
      qcnt      <= '0;
      phase     <= 2'h0;
      bit_idx   <= 4'h0;
      shreg     <= 8'h00;
      rd        <= 1'b0;
      last      <= 1'b0;
      scl_oe_n  <= 1'b1;
      sda_oe_n  <= 1'b1;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_nack  <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      qcnt      <= next_qcnt;
      phase     <= next_phase;
      bit_idx   <= next_bit_idx;
      shreg     <= next_shreg;
      rd        <= next_rd;
      last      <= next_last;
      scl_oe_n  <= next_scl_oe_n;
      sda_oe_n  <= next_sda_oe_n;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
      rsp_nack  <= next_rsp_nack;
    end
  end

  assign bus.sda_mst_o    = 1'b0;
  assign bus.sda_mst_oe_n = sda_oe_n;
  assign bus.scl_mst_o    = 1'b0;
  assign bus.scl_mst_oe_n = scl_oe_n;
endmodule

//--- twi_properties.sv
// Concurrent checks on the open-drain bus between slave and master
`timescale 1ns/10ps
module twi_properties #(
  parameter int TIMEOUT_CYCLES = 2000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe_n,
  input wire logic scl_dev_oe_n,
  input wire logic sda_mst_o,
  input wire logic sda_mst_oe_n,
  input wire logic scl_mst_o,
  input wire logic scl_mst_oe_n,
  input wire logic sda,
  input wire logic scl
);
  // ----------------------------------------------------------------
  // Clock-low counter
  // ----------------------------------------------------------------
  int low_cnt;
  int next_low_cnt;

  always_comb
  begin
    next_low_cnt = scl ? 0 : low_cnt + 1;
  end

  always_ff @(posedge clk)
  begin
    low_cnt <= rst ? 0 : next_low_cnt;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_scl_not_driven: assert property (scl_dev_oe_n)
    else $error("slave drives clock");
  chk_sda_pull_only: assert property (!sda_dev_oe_n |-> !sda_dev_o)
    else $error("slave drives data high");
  chk_quiet_clk_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe_n))
    else $error("slave data moved while clock high");
  chk_drive_clk_low: assert property ($fell(sda_dev_oe_n) |-> !scl)
    else $error("slave pull began with clock high");
  chk_stop_release: assert property ($rose(sda) && scl && $past(scl) |-> sda_dev_oe_n [*4])
    else $error("slave holds data after stop");
  chk_start_release: assert property ($fell(sda) && scl && $past(scl) |=> sda_dev_oe_n [*4])
    else $error("slave holds data after start");
  chk_timeout_free: assert property (low_cnt > TIMEOUT_CYCLES + 8 |-> sda_dev_oe_n)
    else $error("slave holds data after timeout");
  chk_mst_open_drain: assert property (!(!sda_mst_oe_n && sda_mst_o) && !(!scl_mst_oe_n && scl_mst_o))
    else $error("master drives a line high");
endmodule

//--- tb.sv
// Self-checking bench joining the slave and master ends over the bus
`timescale 1ns/10ps
module tb;
  localparam int         TO = 2000;
  localparam logic [7:0] AW = {twi_pkg::ADDR_FIXED, 2'h3, 1'b0};
  localparam logic [7:0] AR = AW | 8'h01;
  logic          clk, rst, rx_ready, rx_valid, cmd_valid, cmd_last;
  logic          cmd_ready, rsp_valid, rsp_nack;
  logic [1:0]    sel, rx_kind;
  logic [7:0]    rx_data, pointer, cmd_data, rsp_data;
  logic [15:0]   reg_rdata;
  twi_pkg::cmd_t cmd_kind;
  int            miscompares, tests_run;
  logic [9:0]    rxq[$];
  twi_if         bus();

  twi_slave #(.TIMEOUT_CYCLES(TO)) i_twi_slave (.clk, .rst, .address_select_pin(sel),
    .reg_rdata, .rx_ready, .rx_valid, .rx_data, .rx_kind, .pointer, .bus(bus));
  twi_master i_twi_master (.clk, .rst, .cmd_valid, .cmd_kind, .cmd_data, .cmd_last,
    .cmd_ready, .rsp_valid, .rsp_data, .rsp_nack, .bus(bus));
  twi_properties #(.TIMEOUT_CYCLES(TO)) i_twi_properties (.clk, .rst,
    .sda_dev_o(bus.sda_dev_o), .sda_dev_oe_n(bus.sda_dev_oe_n),
    .scl_dev_oe_n(bus.scl_dev_oe_n), .sda_mst_o(bus.sda_mst_o),
    .sda_mst_oe_n(bus.sda_mst_oe_n), .scl_mst_o(bus.scl_mst_o),
    .scl_mst_oe_n(bus.scl_mst_oe_n), .sda(bus.sda), .scl(bus.scl));

  // ----------------------------------------------------------------
  // Clock, receive monitor and tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (!rst && rx_valid === 1'b1 && rx_ready)
      rxq.push_back({rx_kind, rx_data});
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Holds the command until the edge that takes it, then waits for completion
  task cmd(input twi_pkg::cmd_t k, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_data <= d;
    cmd_last <= l;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 5000);
    check(16'(rsp_valid), 16'h0001);
  endtask

  task wb(input logic [7:0] d, input logic nack);
    cmd(twi_pkg::CMD_WRITE, d, 0);
    check(rsp_nack, nack);
  endtask

  task pop(input logic [9:0] exp);
    logic [9:0] v;
    v = 'x;
    if (rxq.size() > 0)
      v = rxq.pop_front();
    check(v, exp);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Roughly twice the cycles that the whole sequence should need
  initial
  begin
    #(80000 * 50);
    miscompares++;
    finish_test;
  end

  initial
  begin
    rst = 1;
    rx_ready = 0;
    sel = 0;
    cmd_valid = 0;
    cmd_kind = twi_pkg::CMD_START;
    cmd_data = 0;
    cmd_last = 0;
    reg_rdata = 16'hc3a5;
    miscompares = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst <= 0;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      sel <= s[1:0];
      repeat (4) @(posedge clk);
      cmd(twi_pkg::CMD_START, 0, 0);
      wb({twi_pkg::ADDR_FIXED, s[1:0], 1'b0}, 0);
      cmd(twi_pkg::CMD_STOP, 0, 0);
    end
    cmd(twi_pkg::CMD_START, 0, 0);
    wb({twi_pkg::ADDR_FIXED, 2'h1, 1'b0}, 1);
    cmd(twi_pkg::CMD_STOP, 0, 0);
    $display("test address done");
    // Receiver stalled: two entries fit, the third byte is refused
    cmd(twi_pkg::CMD_START, 0, 0);
    wb(AW, 0);
    wb(8'h01, 0);
    check(pointer, 8'h01);
    wb(8'h5a, 0);
    wb(8'h3c, 1);
    cmd(twi_pkg::CMD_STOP, 0, 0);
    @(posedge clk);
    rx_ready <= 1;
    repeat (4) @(posedge clk);
    pop({twi_pkg::KIND_POINTER, 8'h01});
    pop({twi_pkg::KIND_MSB, 8'h5a});
    check(16'(rxq.size()), 16'h0000);
    $display("test buffer done");
    // Long write cut after an MSB by a repeated start, then a read
    cmd(twi_pkg::CMD_START, 0, 0);
    wb(AW, 0);
    wb(8'h02, 0);
    wb(8'h11, 0);
    wb(8'h22, 0);
    wb(8'h33, 0);
    cmd(twi_pkg::CMD_START, 0, 0);
    wb(AR, 0);
    cmd(twi_pkg::CMD_READ, 0, 0);
    check(rsp_data, 8'hc3);
    cmd(twi_pkg::CMD_READ, 0, 1);
    check(rsp_data, 8'ha5);
    cmd(twi_pkg::CMD_STOP, 0, 0);
    check(pointer, 8'h02);
    pop({twi_pkg::KIND_POINTER, 8'h02});
    pop({twi_pkg::KIND_MSB, 8'h11});
    pop({twi_pkg::KIND_LSB, 8'h22});
    pop({twi_pkg::KIND_MSB, 8'h33});
    check(16'(rxq.size()), 16'h0000);
    $display("test stream done");
    // Clock stalled while the slave pulls a zero bit: it must let go
    @(posedge clk);
    reg_rdata <= 16'hc35a;
    cmd(twi_pkg::CMD_START, 0, 0);
    wb(AR, 0);
    cmd(twi_pkg::CMD_READ, 0, 0);
    check(rsp_data, 8'hc3);
    check(16'(bus.sda), 16'h0000);
    repeat (TO + 500) @(posedge clk);
    check(16'(bus.sda), 16'h0001);
    cmd(twi_pkg::CMD_STOP, 0, 0);
    $display("test stall done");
    // Clock held low past the limit: the slave returns to idle and ignores the byte
    cmd(twi_pkg::CMD_START, 0, 0);
    wb(AW, 0);
    repeat (TO + 500) @(posedge clk);
    wb(8'h07, 1);
    cmd(twi_pkg::CMD_STOP, 0, 0);
    check(16'(rxq.size()), 16'h0000);
    $display("test timeout done");
    finish_test;
  end
endmodule
